// ### cbg_cluster_busy.sv
// Cluster busy generator with its Wishbone register slave
//
// Design decisions made here: the register addresses and register access over Wishbone.
module cbg_cluster_busy
  import cbg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire cbg_wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [N_DET-1:0] detector_busy_in,
  input wire logic acquisition_veto_in,
  input wire logic processor_veto_in,
  input wire logic [N_CLUS-1:0] group_level0_trigger,
  input wire logic [N_CLUS-1:0] second_level_decision,
  output logic [N_CLUS-1:0] cluster_busy_out
);

  //----------------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------------
  logic [N_DET+1:0] pin_s1_reg, pin_s2_reg;
  logic [N_DET-1:0] det_s;
  logic acq_s, proc_s;

  // Two stages for every asynchronous busy pin
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      pin_s1_reg <= {processor_veto_in, acquisition_veto_in,
                     detector_busy_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign det_s = pin_s2_reg[N_DET-1:0];
  assign acq_s = pin_s2_reg[N_DET];
  assign proc_s = pin_s2_reg[N_DET+1];

  //----------------------------------------------------------------------
  // Register slave
  //----------------------------------------------------------------------
  cbg_cfg_t cfg_reg [N_CLUS];
  cbg_cfg_t cfg_next [N_CLUS];
  logic lock_reg, lock_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [N_CLUS-1:0] dead_reg, dead_next;
  logic [N_CLUS-1:0] busy_reg, busy_next;
  logic req, wr;
  logic [2:0] widx;

  assign req = wb_req.cyc && wb_req.stb && !ack_reg;
  assign wr = req && wb_req.we;
  assign widx = wb_req.adr[4:2];

  // Byte-lane merge of a write into a word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Next values of the control words, lock, ack and read data
  always_comb begin
    cfg_next = cfg_reg;
    lock_next = lock_reg;
    ack_next = req;
    rdat_next = 32'h0000_0000;
    if (wr && wb_req.adr <= OFS_CFG_LAST && wb_req.adr[1:0] == 2'b00) begin
      // Physics words are frozen while a run is locked
      if (widx == 3'(TEST_IDX) || !lock_reg) begin
        cfg_next[widx] = merge(cfg_reg[widx], wb_req.dat, wb_req.sel);
      end
    end
    if (wr && wb_req.adr == OFS_CTRL && wb_req.sel[0]) begin
      lock_next = wb_req.dat[CTRL_LOCK_BIT];
    end
    if (req && !wb_req.we) begin
      if (wb_req.adr <= OFS_CFG_LAST && wb_req.adr[1:0] == 2'b00) begin
        rdat_next = cfg_reg[widx];
      end else if (wb_req.adr == OFS_STATUS) begin
        rdat_next[STAT_BUSY_LSB +: N_CLUS] = busy_reg;
        rdat_next[STAT_DEAD_LSB +: N_CLUS] = dead_reg;
      end else if (wb_req.adr == OFS_DET) begin
        rdat_next[N_DET-1:0] = det_s;
      end else if (wb_req.adr == OFS_CTRL) begin
        rdat_next[CTRL_LOCK_BIT] = lock_reg;
      end
    end
  end

  // Register the slave state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int c = 0; c < N_CLUS; c++) begin
        cfg_reg[c] <= CFG_RST;
      end
      lock_reg <= CTRL_LOCK_RST;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      cfg_reg <= cfg_next;
      lock_reg <= lock_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  //----------------------------------------------------------------------
  // Dead time and cluster busy
  //----------------------------------------------------------------------
  logic [N_CLUS-1:0] ovl_dead;
  logic [N_CLUS-1:0] member_busy;
  logic veto;

  // Dead time runs from a cluster trigger to its decision; set wins
  always_comb begin
    dead_next = (dead_reg & ~second_level_decision)
                | group_level0_trigger;
  end

  // Busy per cluster; the short post-trigger hold lives elsewhere
  always_comb begin
    veto = acq_s | proc_s;
    for (int c = 0; c < N_CLUS; c++) begin
      member_busy[c] = |(det_s & cfg_reg[c].members);
    end
    // Physics overlap bits are taken as loaded; the test word's overlap bits act both ways
    for (int c = 0; c < N_PHYS; c++) begin
      ovl_dead[c] = |(cfg_reg[c].overlap & dead_next[N_PHYS-1:0])
                    | (cfg_reg[TEST_IDX].overlap[c]
                       & dead_next[TEST_IDX]);
    end
    ovl_dead[TEST_IDX] = |(cfg_reg[TEST_IDX].overlap
                           & dead_next[N_PHYS-1:0]);
    busy_next = member_busy | dead_next | ovl_dead
                | {N_CLUS{veto}};
  end

  // Register dead time and busy
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dead_reg <= '0;
      busy_reg <= '0;
    end else begin
      dead_reg <= dead_next;
      busy_reg <= busy_next;
    end
  end

  assign cluster_busy_out = busy_reg;

  //----------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  sequence s_new_req;
    wb_req.cyc && wb_req.stb && !wb_ack_o;
  endsequence

  a_dead_start: assert property (
    group_level0_trigger != '0 |=>
      (dead_reg & $past(group_level0_trigger))
        == $past(group_level0_trigger))
    else $error("dead time not started by trigger");

  a_dead_end: assert property (
    (second_level_decision & ~group_level0_trigger) != '0 |=>
      (dead_reg & $past(second_level_decision
                        & ~group_level0_trigger)) == '0)
    else $error("dead time not ended by decision");

  a_dead_hold: assert property (
    ##1 (($past(dead_reg) & ~$past(second_level_decision))
         & ~dead_reg) == '0)
    else $error("dead time dropped early");

  a_dead_busy: assert property (
    group_level0_trigger[0] |=> cluster_busy_out[0]
      throughout (dead_reg[0])[*1])
    else $error("dead cluster not busy");

  a_veto_all: assert property (
    (acq_s || proc_s) |=> cluster_busy_out == '1)
    else $error("global veto missing on a cluster");

  a_member_busy: assert property (
    |(det_s & cfg_reg[0].members) |=> cluster_busy_out[0])
    else $error("member busy not forwarded");

  a_overlap_dead: assert property (
    (cfg_reg[0].overlap[1] && dead_next[1]) |=> cluster_busy_out[0])
    else $error("overlapping dead time not forwarded");

  a_idle_free: assert property (
    (!veto && dead_next == '0 && (det_s & cfg_reg[3].members) == '0
     && (cfg_reg[3].overlap & dead_next[5:0]) == '0
     && !(cfg_reg[TEST_IDX].overlap[3] && dead_next[TEST_IDX]))
      |=> !cluster_busy_out[3])
    else $error("busy without cause");

  a_lock_freeze: assert property (
    (s_new_req and (lock_reg && wb_req.we && wb_req.adr == OFS_CFG0))
      |=> $stable(cfg_reg[0]))
    else $error("physics word changed while locked");

  a_test_write: assert property (
    (s_new_req and (wb_req.we && wb_req.sel == 4'hf
     && wb_req.adr == OFS_CFG_LAST))
      |=> cfg_reg[TEST_IDX] == $past(wb_req.dat))
    else $error("test word not written");

  a_wb_ack: assert property (
    s_new_req |=> s_ack_pulse)
    else $error("ack not a single cycle");

endmodule

// ### cbg_cluster_busy_tb.sv
// Self-checking testbench of the cluster busy generator
module cbg_cluster_busy_tb import cbg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  cbg_wb_req_t wb_req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [N_DET-1:0] det_set = '0;
  logic [1:0] veto_set = '0;
  logic [N_CLUS-1:0] fire = '0;
  logic [N_CLUS-1:0] decide = '0;
  logic [N_DET-1:0] det_b;
  logic acq_b, proc_b;
  logic [N_CLUS-1:0] l0, l1, cluster_busy_out;
  int err_total = 0;
  int tests_run = 0;
  //----------------------------------------------------------------
  // Clock, design and far side
  //----------------------------------------------------------------
  always #10 ref_clk = ~ref_clk;
  cbg_cluster_busy dut (.ref_clk(ref_clk), .rst(rst), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .detector_busy_in(det_b),
    .acquisition_veto_in(acq_b), .processor_veto_in(proc_b),
    .group_level0_trigger(l0), .second_level_decision(l1),
    .cluster_busy_out(cluster_busy_out));
  cbg_far_side far (.ref_clk(ref_clk), .det_set(det_set),
    .veto_set(veto_set), .fire(fire), .decide(decide),
    .detector_busy_in(det_b), .acquisition_veto_in(acq_b),
    .processor_veto_in(proc_b), .group_level0_trigger(l0),
    .second_level_decision(l1));
  //----------------------------------------------------------------
  // Shared tasks
  //----------------------------------------------------------------
  task print_verdict;
    if (err_total == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    tests_run++;
    if (seen !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One classic cycle, held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] q);
    wb_req <= '{cyc:1'b1, stb:1'b1, we:w, sel:4'hf, adr:a, dat:d};
    @(posedge ref_clk);
    // No timeout here: only the watchdog ends a wait for an ack that never comes
    while (wb_ack_o !== 1'b1) begin
      @(posedge ref_clk);
    end
    q = wb_dat_o;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task chkb(input logic [6:0] e);
    chk("busy", {25'h0, cluster_busy_out}, {25'h0, e});
  endtask
  // One-cycle trigger and decision, then wait until busy has settled
  task pulse(input logic [6:0] f, input logic [6:0] d);
    fire <= f;
    decide <= d;
    tick(1);
    fire <= '0;
    decide <= '0;
    tick(2);
  endtask
  //----------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------
  task t_regs;
    rd("cfg0", OFS_CFG0, CFG_RST);
    rd("ctrl", OFS_CTRL, 32'h0);
    wr(8'h80, 32'hffff_ffff);
    rd("unmapped", 8'h80, 32'h0);
    wr(OFS_CFG_LAST, 32'hc000_0000);
    rd("test word", OFS_CFG_LAST, 32'hc000_0000);
  endtask
  task t_members;
    wr(OFS_CFG0, 32'h0000_0008);
    det_set <= 24'h000008;
    tick(6);
    chkb(7'h01);
    rd("det", OFS_DET, 32'h0000_0008);
    det_set <= 24'h000010;
    tick(6);
    chkb(7'h00);
    det_set <= '0;
  endtask
  task t_dead;
    wr(OFS_CFG0, 32'h0200_0008);
    wr(OFS_CFG0 + 8'h04, 32'h0100_0000);
    pulse(7'h02, 7'h00);
    chkb(7'h03);
    rd("status", OFS_STATUS, 32'h0000_0203);
    pulse(7'h02, 7'h02);
    chkb(7'h03);
    pulse(7'h00, 7'h02);
    chkb(7'h00);
    pulse(7'h04, 7'h00);
    chkb(7'h04);
    pulse(7'h00, 7'h04);
    pulse(7'h01, 7'h00);
    chkb(7'h03);
    pulse(7'h00, 7'h01);
    chkb(7'h00);
  endtask
  task t_veto;
    for (int i = 1; i < 4; i++) begin
      veto_set <= i[1:0];
      tick(6);
      chkb(7'h7f);
    end
    veto_set <= '0;
    tick(6);
  endtask
  task t_lock;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CFG0, 32'h0000_00ff);
    rd("locked cfg0", OFS_CFG0, 32'h0200_0008);
    wr(OFS_CFG_LAST, 32'h0000_0020);
    det_set <= 24'h000020;
    tick(6);
    chkb(7'h40);
    det_set <= '0;
    // Test cluster dead time reaches the physics cluster it overlaps
    wr(OFS_CFG_LAST, 32'h0400_0000);
    pulse(7'h40, 7'h00);
    chkb(7'h44);
    pulse(7'h00, 7'h40);
    chkb(7'h00);
  endtask
  //----------------------------------------------------------------
  // Main sequence and watchdog
  //----------------------------------------------------------------
  initial begin
    tick(16);
    rst <= 1'b0;
    tick(1);
    t_regs();
    t_members();
    t_dead();
    t_veto();
    t_lock();
    print_verdict();
  end
  initial begin
    tick(5000);
    err_total++;
    print_verdict();
  end
endmodule

// ### cbg_far_side.sv
// Far-side model: sub-detector busy sources and first level trigger logic
module cbg_far_side
  import cbg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [N_DET-1:0] det_set,
  input wire logic [1:0] veto_set,
  input wire logic [N_CLUS-1:0] fire,
  input wire logic [N_CLUS-1:0] decide,
  output logic [N_DET-1:0] detector_busy_in,
  output logic acquisition_veto_in,
  output logic processor_veto_in,
  output logic [N_CLUS-1:0] group_level0_trigger,
  output logic [N_CLUS-1:0] second_level_decision
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sources settle one cycle after being commanded
  always_ff @(posedge ref_clk) begin
    detector_busy_in <= det_set;
    acquisition_veto_in <= veto_set[0];
    processor_veto_in <= veto_set[1];
    group_level0_trigger <= fire;
    second_level_decision <= decide;
  end
endmodule

// ### cbg_pkg.sv
// Constants, register map and carrier types of the cluster busy generator
//------------------------------------------------------------------------
// Overview of operation
// - Seven busy circuits: six physics, one test
// - Busy ORs selected sub-detector busy inputs
// - Physics words fixed per run; test anytime
// - First level trigger starts cluster dead time
// - Overlapping clusters' dead times join busy
// - Word: 24-bit member mask, 6-bit overlap
// - Test cluster has its own word
// - Acquisition and processor vetoes join all busies
// - Global post-trigger hold is not made here
//------------------------------------------------------------------------
package cbg_pkg;

  localparam int N_PHYS = 6;
  localparam int N_CLUS = 7;
  localparam int N_DET = 24;
  localparam int TEST_IDX = 6;

  // Register byte offsets
  localparam logic [7:0] OFS_CFG0 = 8'h00;
  localparam logic [7:0] OFS_CFG_LAST = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_DET = 8'h20;
  localparam logic [7:0] OFS_CTRL = 8'h24;

  // Field positions
  localparam int STAT_BUSY_LSB = 0;
  localparam int STAT_DEAD_LSB = 8;
  localparam int CTRL_LOCK_BIT = 0;

  // Reset values
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic CTRL_LOCK_RST = 1'b0;

  // One cluster control word
  typedef struct packed {
    logic [1:0] spare;
    logic [5:0] overlap;
    logic [23:0] members;
  } cbg_cfg_t;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } cbg_wb_req_t;

endpackage
